/* File: sct_device.sv */
// Device end: bit-addressed registers, interval timer and interrupt output
// Notes on behaviour
// R1 - Reset command clears elapsed, overrun; sets load
// R2 - Load flag falling copies interval into counter
// R3 - Step every 64 ticks, two in test
// R4 - At zero reload counter, set elapsed
// R5 - Elapsed still set at expiry sets overrun
// R6 - Interrupt low when any enabled source pending
// R7 - Writing bit 21 clears modem change
// R8 - Writing bit 18 clears receive full
// R9 - Loading transmit buffer clears transmit empty
// R10 - Writing bit 20 clears timer interrupt
// R11 - Writing zero clears and disables source; for transmit it only disables
// R12 - Transmit line high while not transmitting
// R13 - Receive idles high; falling edge starts receiver
// R14 - Request-to-send host controlled, low while sending
// R15 - Transmitter enabled only while clear-to-send low
// R16 - Any data-set-ready change raises modem change
// R17 - Host drives five-bit select, S4 least significant
// R18 - Strobe high only with valid data; captured
// R19 - Chip enable high: ignore, read line released
// R20 - Host resets via bit 31, then loads registers
// R21 - Internal clock is input clock over three
// R22 - Twelve-bit transmit rate load fills both rates
// R23 - Load flag clears after register's last bit
// R24 - Interrupt is OR of flag AND enable
//
// The register offsets and the APB slave port were left to the implementer.
`default_nettype none
`include "sct_defs.svh"

module sct_device #(
    parameter int TICKS_NORMAL = `SCT_TICKS_NORMAL,
    parameter int TICKS_TEST   = `SCT_TICKS_TEST,
    parameter int CLK_DIV      = `SCT_CLK_DIV
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    // Host bit interface
    sct_bus_if.device                   bus,
    // Serial and modem lines
    output var  logic                   serialTxOut,
    input  wire logic                   serialRxIn,
    output var  logic                   rts_b,
    input  wire logic                   cts_b,
    input  wire logic                   dataSetReady,
    // Transmitter and receiver character path
    input  wire logic                   txShifting,
    input  wire logic                   txSerialBit,
    input  wire logic                   txBufferTaken,
    output var  logic [`SCT_CHAR_W-1:0] txBufferData,
    output var  logic                   txEnable,
    input  wire logic                   rxCharValid,
    input  wire logic [`SCT_CHAR_W-1:0] rxChar,
    output var  logic                   rxActive,
    // Interrupt and rate settings
    output var  logic                   irq_b,
    output var  logic [`SCT_RX_RATE_W-1:0] rxRate,
    output var  logic [`SCT_TX_RATE_W-1:0] txRate
);
    import sct_pkg::*;

    sct_dev_state_t s;
    sct_dev_state_t next_s;
    logic           tick;
    logic           hostWrite;
    logic           stepDue;
    logic [4:0]     sel;
    logic           d;

    // Internal clock is the input clock divided by three
    sct_clk_div #(.DIV(CLK_DIV)) clkDiv ( // R21
        .mclk  (mclk),
        .rst_b (rst_b),
        .tick  (tick)
    );

    // Step limit depends on the test mode bit
    function automatic logic lastTick(input logic [5:0] pre, input logic test);
        lastTick = test ? (pre == 6'(TICKS_TEST - 1)) : (pre == 6'(TICKS_NORMAL - 1));
    endfunction

    // Single-bit read decode
    function automatic logic readBit(input sct_dev_state_t st, input logic [4:0] a,
                                     input logic [`SCT_CHAR_W-1:0] ch, input logic cts,
                                     input logic dsr);
        readBit = 1'b0;
        if (a <= `SCT_RB_CHAR_LAST)
            readBit = ch[a[2:0]];
        else
        begin
            case (a)
                `SCT_RB_RX_ACTIVE:    readBit = st.rxActive;
                `SCT_RB_RX_FULL:      readBit = st.rxFull;
                `SCT_RB_TX_EMPTY:     readBit = st.txEmpty;
                `SCT_RB_ELAPSED:      readBit = st.intervalElapsed;
                `SCT_RB_OVERRUN:      readBit = st.intervalOverrun;
                `SCT_RB_DSR:          readBit = dsr;
                `SCT_RB_CTS:          readBit = cts;
                `SCT_RB_MODEM_CHANGE: readBit = st.modemChange;
                `SCT_RB_IRQ:          readBit = ~st.irq_b;
                default:              readBit = 1'b0;
            endcase
        end
    endfunction

    assign sel = bus.bitSelect; // R17
    assign d = bus.bitWriteLine;
    // Strobe edge: a long strobe writes once
    assign hostWrite = !bus.chipEnable_b && bus.bitWriteStrobe && !s.strobePrev; // R18 R19
    assign stepDue = tick && lastTick(s.prescale, s.testMode);

    // Next-state logic: host writes first, hardware events after so sets win
    always_comb
    begin
        next_s = s;
        next_s.strobePrev = bus.bitWriteStrobe;
        next_s.primed = 1'b1;
        if (hostWrite)
        begin
            if (sel < `SCT_WB_DATA_LIMIT)
            begin
                if (s.intervalLoad)
                begin
                    if (sel <= `SCT_WB_INTERVAL_LAST)
                        next_s.intervalReg[sel[2:0]] = d;
                    if (sel == `SCT_WB_INTERVAL_LAST)
                        next_s.intervalLoad = 1'b0; // R23
                end
                else if (s.rxRateLoad || s.txRateLoad)
                begin
                    // Both flags set: one 12-bit load fills both rates
                    if (s.rxRateLoad && sel <= `SCT_WB_RX_RATE_LAST)
                        next_s.rxRate[sel[3:0]] = d; // R22
                    if (s.txRateLoad)
                        next_s.txRate[sel[3:0]] = d; // R22
                    if (sel == `SCT_WB_RX_RATE_LAST)
                        next_s.rxRateLoad = 1'b0; // R23
                    if (sel == `SCT_WB_TX_RATE_LAST)
                        next_s.txRateLoad = 1'b0; // R23
                end
                else if (sel <= `SCT_WB_TXBUF_LAST)
                begin
                    next_s.txBuffer[sel[2:0]] = d;
                    if (sel == `SCT_WB_TXBUF_LAST)
                        next_s.txEmpty = 1'b0; // R9
                end
            end
            else
            begin
                case (sel)
                    `SCT_WB_LOAD_INTERVAL: next_s.intervalLoad = d;
                    `SCT_WB_TEST_MODE:     next_s.testMode = d;
                    `SCT_WB_RTS_ON:        next_s.rtsOn = d;
                    `SCT_WB_RX_IRQ_EN:
                    begin
                        next_s.enRx = d; // R11
                        next_s.rxFull = 1'b0; // R8
                    end
                    `SCT_WB_TX_IRQ_EN:     next_s.enTx = d;
                    `SCT_WB_TIMER_IRQ_EN:
                    begin
                        next_s.enTimer = d; // R11
                        next_s.intervalElapsed = 1'b0; // R10
                    end
                    `SCT_WB_MODEM_IRQ_EN:
                    begin
                        next_s.enModem = d; // R11
                        next_s.modemChange = 1'b0; // R7
                    end
                    `SCT_WB_RESET_CMD:
                    begin
                        if (d)
                        begin
                            next_s.intervalElapsed = 1'b0; // R1
                            next_s.intervalOverrun = 1'b0; // R1
                            next_s.intervalLoad = 1'b1; // R1
                            next_s.rxRateLoad = 1'b1;
                            next_s.txRateLoad = 1'b1;
                            next_s.enModem = 1'b0;
                            next_s.enRx = 1'b0;
                            next_s.enTx = 1'b0;
                            next_s.enTimer = 1'b0;
                            next_s.rtsOn = 1'b0;
                            next_s.testMode = 1'b0;
                            next_s.txEmpty = 1'b1;
                            next_s.rxFull = 1'b0;
                            next_s.rxActive = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Interval timer, frozen while loading
        if (s.intervalLoad && !next_s.intervalLoad)
        begin
            next_s.intervalCount = next_s.intervalReg; // R2
            next_s.prescale = 6'h00;
        end
        else if (tick && !next_s.intervalLoad)
        begin
            next_s.prescale = stepDue ? 6'h00 : s.prescale + 6'h01; // R3
            if (stepDue)
            begin
                if (s.intervalCount <= 8'h01)
                begin
                    next_s.intervalCount = s.intervalReg; // R4
                    next_s.intervalElapsed = 1'b1; // R4
                    if (s.intervalElapsed)
                        next_s.intervalOverrun = 1'b1; // R5
                end
                else
                    next_s.intervalCount = s.intervalCount - 8'h01;
            end
        end

        // Modem changes; first cycle only primes history
        next_s.ctsPrev = cts_b;
        next_s.dsrPrev = dataSetReady;
        if (s.primed && (cts_b != s.ctsPrev || dataSetReady != s.dsrPrev))
            next_s.modemChange = 1'b1; // R16

        // Receiver wake-up on a falling receive line
        next_s.rxPrev = serialRxIn;
        if (s.rxPrev && !serialRxIn)
            next_s.rxActive = 1'b1; // R13
        if (rxCharValid)
        begin
            next_s.rxActive = 1'b0;
            next_s.rxFull = 1'b1;
        end
        if (txBufferTaken)
            next_s.txEmpty = 1'b1;

        // Modem controls and serial output
        next_s.rts_b = !(next_s.rtsOn || txShifting); // R14
        next_s.txEnable = !cts_b && !next_s.rts_b; // R15
        next_s.txOut = txShifting ? txSerialBit : 1'b1; // R12

        // Interrupt: OR of each pending flag gated by its enable
        next_s.irq_b = !((next_s.modemChange && next_s.enModem) ||
                         (next_s.rxFull && next_s.enRx) ||
                         (next_s.txEmpty && next_s.enTx) ||
                         (next_s.intervalElapsed && next_s.enTimer)); // R6 R24

        // Read line follows select one cycle later, released when deselected
        next_s.readLine = readBit(s, sel, rxChar, cts_b, dataSetReady);
        next_s.readOe = !bus.chipEnable_b; // R19
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.intervalLoad <= 1'b1;
            s.rxRateLoad <= 1'b1;
            s.txRateLoad <= 1'b1;
            s.txEmpty <= 1'b1;
            s.ctsPrev <= 1'b1;
            s.rxPrev <= 1'b1;
            s.irq_b <= 1'b1;
            s.rts_b <= 1'b1;
            s.txOut <= 1'b1;
        end
        else
            s <= next_s;
    end

    // Outputs straight from the state register
    assign bus.bitReadLine = s.readLine;
    assign bus.bitReadOe = s.readOe;
    assign serialTxOut = s.txOut;
    assign rts_b = s.rts_b;
    assign txEnable = s.txEnable;
    assign txBufferData = s.txBuffer;
    assign rxActive = s.rxActive;
    assign irq_b = s.irq_b;
    assign rxRate = s.rxRate;
    assign txRate = s.txRate;
endmodule

`default_nettype wire

/* File: sct_defs.svh */
// Constants for the serial controller interval timer and its host bit interface
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

// Internal clock divide and timer step figures
`define SCT_CLK_DIV          3
`define SCT_TICKS_NORMAL     64
`define SCT_TICKS_TEST       2

// Register widths
`define SCT_INTERVAL_W       8
`define SCT_RX_RATE_W        11
`define SCT_TX_RATE_W        12
`define SCT_CHAR_W           8

// Write bit addresses
`define SCT_WB_INTERVAL_LAST 5'h07
`define SCT_WB_TXBUF_LAST    5'h07
`define SCT_WB_RX_RATE_LAST  5'h0A
`define SCT_WB_TX_RATE_LAST  5'h0B
`define SCT_WB_DATA_LIMIT    5'h0C
`define SCT_WB_LOAD_INTERVAL 5'h0D
`define SCT_WB_TEST_MODE     5'h0F
`define SCT_WB_RTS_ON        5'h10
`define SCT_WB_RX_IRQ_EN     5'h12
`define SCT_WB_TX_IRQ_EN     5'h13
`define SCT_WB_TIMER_IRQ_EN  5'h14
`define SCT_WB_MODEM_IRQ_EN  5'h15
`define SCT_WB_RESET_CMD     5'h1F

// Read bit addresses
`define SCT_RB_CHAR_LAST     5'h07
`define SCT_RB_RX_ACTIVE     5'h14
`define SCT_RB_RX_FULL       5'h15
`define SCT_RB_TX_EMPTY      5'h16
`define SCT_RB_ELAPSED       5'h18
`define SCT_RB_OVERRUN       5'h19
`define SCT_RB_DSR           5'h1A
`define SCT_RB_CTS           5'h1B
`define SCT_RB_MODEM_CHANGE  5'h1E
`define SCT_RB_IRQ           5'h1F

// Host APB register map
`define SCT_APB_ADDR_W       12
`define SCT_OFF_CMD          12'h000
`define SCT_OFF_STATUS       12'h004
`define SCT_CMD_SEL_LSB      0
`define SCT_CMD_DATA_BIT     8
`define SCT_CMD_WRITE_BIT    9
`define SCT_STAT_BUSY_BIT    0
`define SCT_STAT_RDATA_BIT   8

`endif

/* File: sct_pkg.sv */
// Types shared by both ends of the serial controller bit interface
`default_nettype none
`include "sct_defs.svh"

package sct_pkg;

    // Host sequencer states
    typedef enum logic [1:0] {hIdle, hSetup, hAct, hDone} sct_host_state_t;

    // Whole device state
    typedef struct packed {
        logic [`SCT_INTERVAL_W-1:0] intervalReg;
        logic [`SCT_INTERVAL_W-1:0] intervalCount;
        logic [5:0]                 prescale;
        logic                       intervalElapsed;
        logic                       intervalOverrun;
        logic                       intervalLoad;
        logic                       rxRateLoad;
        logic                       txRateLoad;
        logic [`SCT_RX_RATE_W-1:0]  rxRate;
        logic [`SCT_TX_RATE_W-1:0]  txRate;
        logic [`SCT_CHAR_W-1:0]     txBuffer;
        logic                       txEmpty;
        logic                       rxFull;
        logic                       modemChange;
        logic                       enModem;
        logic                       enRx;
        logic                       enTx;
        logic                       enTimer;
        logic                       rtsOn;
        logic                       testMode;
        logic                       primed;
        logic                       strobePrev;
        logic                       ctsPrev;
        logic                       dsrPrev;
        logic                       rxPrev;
        logic                       rxActive;
        logic                       irq_b;
        logic                       readLine;
        logic                       readOe;
        logic                       rts_b;
        logic                       txEnable;
        logic                       txOut;
    } sct_dev_state_t;

    // Whole host state
    typedef struct packed {
        sct_host_state_t state;
        logic [4:0]      select;
        logic            wdata;
        logic            isWrite;
        logic            strobe;
        logic            chipEnable_b;
        logic            readBit;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } sct_host_state_s_t;

endpackage

`default_nettype wire

/* File: sct_bus_if.sv */
// Bit-addressed host interface joining the host end and the device end
`default_nettype none

interface sct_bus_if;
    logic [4:0] bitSelect;
    logic       bitWriteLine;
    logic       bitWriteStrobe;
    logic       chipEnable_b;
    logic       bitReadLine;
    logic       bitReadOe;

    // Device end
    modport device (
        input  bitSelect,
        input  bitWriteLine,
        input  bitWriteStrobe,
        input  chipEnable_b,
        output bitReadLine,
        output bitReadOe
    );

    // Host end
    modport host (
        output bitSelect,
        output bitWriteLine,
        output bitWriteStrobe,
        output chipEnable_b,
        input  bitReadLine,
        input  bitReadOe
    );
endinterface

`default_nettype wire

/* File: sct_clk_div.sv */
// Divider giving a one-cycle internal clock tick every DIV input clocks
`default_nettype none
`include "sct_defs.svh"

module sct_clk_div #(
    parameter int DIV = `SCT_CLK_DIV
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Internal clock tick
    output var  logic tick
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic       next_tick;

    // Free-running modulo counter
    always_comb
    begin
        next_tick = (count == 4'(DIV - 1));
        next_count = next_tick ? 4'h0 : count + 4'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            count <= 4'h0;
            tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

`default_nettype wire

/* File: sct_host.sv */
// Host end: APB command registers driving single-bit reads and writes
`default_nettype none
`include "sct_defs.svh"

module sct_host (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`SCT_APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    // Device bit interface
    sct_bus_if.host                         bus
);
    import sct_pkg::*;

    sct_host_state_s_t h;
    sct_host_state_s_t next_h;
    logic              setupPhase;
    logic              accessDone;
    logic              busy;

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && h.pready;
    assign busy = (h.state != hIdle);

    // Bus slave and bit sequencer
    always_comb
    begin
        next_h = h;
        // Answer one cycle after setup: zero wait states
        next_h.pready = setupPhase;
        if (setupPhase)
        begin
            next_h.pslverr = 1'b0;
            next_h.prdata = 32'h0000_0000;
            case (paddr)
                `SCT_OFF_CMD:
                begin
                    next_h.prdata[`SCT_CMD_SEL_LSB +: 5] = h.select;
                    next_h.prdata[`SCT_CMD_DATA_BIT] = h.wdata;
                    next_h.prdata[`SCT_CMD_WRITE_BIT] = h.isWrite;
                end
                `SCT_OFF_STATUS:
                begin
                    next_h.prdata[`SCT_STAT_BUSY_BIT] = busy;
                    next_h.prdata[`SCT_STAT_RDATA_BIT] = h.readBit;
                end
                default: next_h.pslverr = 1'b1;
            endcase
        end

        // Command taken at the access edge; dropped while a bit is in flight
        if (accessDone && pwrite && paddr == `SCT_OFF_CMD && !busy)
        begin
            // Reset command and load order are a software sequence of such commands
            next_h.select = pwdata[`SCT_CMD_SEL_LSB +: 5]; // R17 R20
            next_h.wdata = pwdata[`SCT_CMD_DATA_BIT];
            next_h.isWrite = pwdata[`SCT_CMD_WRITE_BIT];
            next_h.state = hSetup;
        end

        case (h.state)
            hIdle:
            begin
                next_h.chipEnable_b = 1'b1;
                next_h.strobe = 1'b0;
            end
            hSetup:
            begin
                // Chip enable falls one cycle before the strobe; select and data settled one cycle before that
                next_h.chipEnable_b = 1'b0;
                next_h.state = hAct;
            end
            hAct:
            begin
                next_h.strobe = h.isWrite; // R18
                next_h.state = hDone;
            end
            hDone:
            begin
                // Strobe falls while data is still held
                next_h.strobe = 1'b0;
                if (!h.isWrite)
                    next_h.readBit = bus.bitReadLine;
                next_h.state = hIdle;
            end
            default: next_h.state = hIdle;
        endcase
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            h <= '0;
            h.state <= hIdle;
            h.chipEnable_b <= 1'b1;
        end
        else
            h <= next_h;
    end

    // Outputs straight from the state register
    assign prdata = h.prdata;
    assign pready = h.pready;
    assign pslverr = h.pslverr;
    assign bus.bitSelect = h.select;
    assign bus.bitWriteLine = h.wdata;
    assign bus.bitWriteStrobe = h.strobe;
    assign bus.chipEnable_b = h.chipEnable_b;
endmodule

`default_nettype wire

/* File: sct_bus_assertions.sv */
// Concurrent checks on the bit interface and the device line outputs
`default_nettype none
module sct_bus_assertions (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_b,
    // Bit interface
    input wire logic [4:0] bitSelect,
    input wire logic       bitWriteStrobe,
    input wire logic       chipEnable_b,
    input wire logic       bitReadOe,
    // Serial and modem lines
    input wire logic       txShifting,
    input wire logic       serialTxOut,
    input wire logic       rts_b,
    input wire logic       cts_b,
    input wire logic       txEnable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // Read driver lags chip enable by one edge, so it lets go of the line when idle
    a_oe_tracks_ce: assert property (bitReadOe == !$past(chipEnable_b))
        else $error("read enable off");
    // Strobe only inside an access, one cycle, with a steady select
    a_strobe_in_ce: assert property (bitWriteStrobe |-> !chipEnable_b)
        else $error("strobe outside access");
    a_strobe_single: assert property (bitWriteStrobe |=> !bitWriteStrobe)
        else $error("strobe too long");
    a_select_held: assert property (bitWriteStrobe |-> $stable(bitSelect))
        else $error("select moved");
    a_access_span: assert property ($fell(chipEnable_b) |-> !chipEnable_b [*3] ##1 chipEnable_b)
        else $error("access span");
    // Line outputs are registered, hence the one-edge lag
    a_tx_idle_high: assert property (!$past(txShifting) |-> serialTxOut)
        else $error("tx line low while idle");
    a_rts_sending: assert property ($past(txShifting) |-> !rts_b)
        else $error("rts high while sending");
    a_tx_needs_cts: assert property (txEnable |-> !$past(cts_b))
        else $error("tx enabled without cts");
    a_tx_follows: assert property (!$past(cts_b) && !$past(rts_b) |-> txEnable)
        else $error("tx not enabled");
    cover property ($rose(txEnable));
    cover property (bitWriteStrobe);
    cover property ($rose(bitReadOe));
endmodule
`default_nettype wire

/* File: testbench.sv */
// Bench joining the host and device ends over the bit interface
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, slvErr, rdBit;
    logic        serialRxIn = 1'b1, cts_b = 1'b1, dsr = 1'b0, txShifting = 1'b0, txBit = 1'b1, taken = 1'b0;
    logic        rxValid = 1'b0, serialTxOut, rts_b, txEnable, rxActive, irq_b;
    logic [11:0] paddr = 12'h000, txRate;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [10:0] rxRate;
    logic [7:0]  rxChar = 8'hA5, txData;
    int          err_count = 0, check_count = 0;
    sct_bus_if bus ();
    sct_host i_sct_host (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus);
    sct_device i_sct_device (.mclk, .rst_b, .bus, .serialTxOut, .serialRxIn, .rts_b, .cts_b, .dataSetReady(dsr),
        .txShifting, .txSerialBit(txBit), .txBufferTaken(taken), .txBufferData(txData), .txEnable,
        .rxCharValid(rxValid), .rxChar, .rxActive, .irq_b, .rxRate, .txRate);
    sct_bus_assertions i_sct_bus_assertions (.mclk, .rst_b, .bitSelect(bus.bitSelect),
        .bitWriteStrobe(bus.bitWriteStrobe), .chipEnable_b(bus.chipEnable_b), .bitReadOe(bus.bitReadOe),
        .txShifting, .serialTxOut, .rts_b, .cts_b, .txEnable);
    // 20 MHz clock
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    // Hang guard, well past run length
    initial
    begin
        #1000000;
        err_count++;
        summarize();
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        r = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bit access: command, then poll busy
    task automatic bop(input logic [4:0] s, input logic w, input logic d);
        logic [31:0] r;
        apb(1'b1, 12'h000, {22'h0, w, d, 3'h0, s}, r);
        r = 32'h1;
        while (r[0] !== 1'b0)
            apb(1'b0, 12'h004, 32'h0, r);
        rdBit = r[8];
    endtask
    task automatic rchk(input logic [4:0] s, input logic e, input string n);
        bop(s, 1'b0, 1'b0);
        chk(n, e, rdBit);
    endtask
    task automatic ld(input logic [11:0] v, input int n);
        for (int i = 0; i < n; i++)
            bop(5'(i), 1'b1, v[i]);
    endtask
    task automatic wirq(input logic e);
        for (int i = 0; i < 900 && irq_b !== e; i++)
            @(posedge mclk);
        chk("irq_b", e, irq_b);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        bop(5'h1F, 1'b1, 1'b1);
        rchk(5'h18, 1'b0, "elapsed");
        rchk(5'h16, 1'b1, "tx empty");
        chk("irq_b", 1'b1, irq_b);
        apb(1'b0, 12'h008, 32'h0, r);
        chk("pslverr", 1'b1, slvErr);
        chk("prdata", 32'h0, r);
    endtask
    // Interval 4: expiry 768 mclk after load
    task automatic t_timer();
        ld(12'h004, 8);
        repeat (400) @(posedge mclk);
        rchk(5'h18, 1'b0, "elapsed early");
        repeat (400) @(posedge mclk);
        rchk(5'h18, 1'b1, "elapsed");
        repeat (800) @(posedge mclk);
        rchk(5'h19, 1'b1, "overrun");
        bop(5'h14, 1'b1, 1'b1);
        wirq(1'b0);
        rchk(5'h1F, 1'b1, "pending");
        bop(5'h14, 1'b1, 1'b0);
        chk("irq_b", 1'b1, irq_b);
        repeat (800) @(posedge mclk);
        rchk(5'h18, 1'b1, "elapsed masked");
        chk("irq_b", 1'b1, irq_b);
        ld(12'hA5C, 12);
        chk("rx rate", 11'h25C, rxRate);
        chk("tx rate", 12'hA5C, txRate);
    endtask
    task automatic t_rx();
        serialRxIn <= 1'b0;
        @(posedge mclk);
        serialRxIn <= 1'b1;
        rchk(5'h14, 1'b1, "rx active");
        bop(5'h12, 1'b1, 1'b1);
        rxValid <= 1'b1;
        @(posedge mclk);
        rxValid <= 1'b0;
        wirq(1'b0);
        rchk(5'h14, 1'b0, "rx idle");
        bop(5'h12, 1'b1, 1'b0);
        chk("irq_b", 1'b1, irq_b);
        rchk(5'h15, 1'b0, "rx full");
        bop(5'h15, 1'b1, 1'b1);
        dsr <= 1'b1;
        wirq(1'b0);
        bop(5'h15, 1'b1, 1'b0);
        chk("irq_b", 1'b1, irq_b);
    endtask
    task automatic t_tx();
        bop(5'h13, 1'b1, 1'b1);
        taken <= 1'b1;
        @(posedge mclk);
        taken <= 1'b0;
        wirq(1'b0);
        ld(12'h03C, 8);
        chk("irq_b", 1'b1, irq_b);
        chk("tx data", 8'h3C, txData);
        bop(5'h10, 1'b1, 1'b1);
        cts_b <= 1'b0;
        txShifting <= 1'b1;
        txBit <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("tx enable", 1'b1, txEnable);
        chk("tx out", 1'b0, serialTxOut);
        txShifting <= 1'b0;
        cts_b <= 1'b1;
        bop(5'h10, 1'b1, 1'b0);
        chk("rts_b", 1'b1, rts_b);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset, then scenarios
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_rx();
        t_tx();
        summarize();
    end
endmodule
`default_nettype wire
